// ---- tsens_cfg.svh ----
`ifndef TSENS_CFG_SVH
`define TSENS_CFG_SVH
// Pointer addresses
`define PTR_TEMP 4'h0
`define PTR_CONFIG 4'h1
`define PTR_HIGH_A 4'h2
`define PTR_LOW_A 4'h3
`define PTR_HIGH_B 4'h4
`define PTR_LOW_B 4'h5
// Reset values
`define CONFIG_RESET 16'ha000
`define TEMP_RESET 14'h0000
`define LIMIT_HIGH_RESET 16'h7ff0
`define LIMIT_LOW_RESET 16'h8000
// Configuration field positions
`define BIT_RATE_HI 15
`define BIT_RATE_LO 13
`define BIT_SINGLE 12
`define BIT_POWERDOWN 11
`define BIT_OVER_A 10
`define BIT_UNDER_A 9
`define BIT_BEHAV_A 8
`define BIT_LEVEL_A 7
`define BIT_OVER_B 6
`define BIT_UNDER_B 5
`define BIT_BEHAV_B 4
`define BIT_LEVEL_B 3
`define BIT_SOFT_RESET 1
// Nonvolatile programming time
`define NVM_PROG_MS 16
`define CLK_HZ 20000000
`define NVM_PROG_CYCLES ((`NVM_PROG_MS * `CLK_HZ) / 1000)
`endif

// ---- tsens_pkg.sv ----
package tsens_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] ptr;
    logic [15:0] data;
  } reg_req_t;
  typedef struct packed {
    logic [13:0] code;
    logic valid;
  } conv_result_t;
  typedef enum logic [2:0] {
    CONV_IDLE = 3'b001,
    CONV_RUN = 3'b010,
    CONV_SINGLE = 3'b100
  } conv_state_t;
endpackage

// ---- tsens_nvm_timer.sv ----
`timescale 1ns/10ps
`include "tsens_cfg.svh"
module tsens_nvm_timer #(
  parameter int unsigned PROG_CYCLES = `NVM_PROG_CYCLES
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Control
  input wire logic i_start,
  output logic o_busy
);
  logic [23:0] cnt_reg;
  logic [23:0] cnt_next;

  // Busy while programming; starts are ignored until done
  always_comb begin
    cnt_next = cnt_reg;
    if (cnt_reg != 24'h000000) begin
      cnt_next = cnt_reg - 24'h000001;
    end else if (i_start) begin
      cnt_next = PROG_CYCLES[23:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      cnt_reg <= 24'h000000;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign o_busy = (cnt_reg != 24'h000000);

  a_busy_ignores_start: assert property (@(posedge i_clk) disable iff // R3
    (!i_resetn) o_busy |=>
    (cnt_reg == $past(cnt_reg) - 24'h000001))
    else $error("start accepted while busy");
endmodule

// ---- tsens_regs.sv ----
`timescale 1ns/10ps
`include "tsens_cfg.svh"
// Behaviour
// R1: Temperature bits 15:2 hold latest 14-bit signed result, reset zero.
// R2: Temperature bit 1 reads busy while nonvolatile memory operates.
// R3: Memory commands arriving while busy are ignored.
// R4: Temperature bit 0 is read/write unlock state, reset zero.
// R5: Configuration register at pointer 1, resets to a000.
// R6: Locked configuration writes update only the volatile register.
// R7: Unlocked configuration writes program nonvolatile copy, taking 16 ms.
// R8: Any configuration write aborts conversion; shutdown acts at once.
// R9: Rate change discards conversion and restarts at new rate.
// R10: Bits 15:13 select continuous rate, reset 5, no single-shot effect.
// R11: Trigger bit 12 in shutdown starts one conversion, then shutdown.
// R12: Trigger bit always reads zero.
// R13: Bit 11 selects continuous (0) or shutdown (1).
// R14: Bit 10 flags result above first high limit.
// R15: Read-only bits ignore writes; soft reset and reserved bits read 0.
// R16: Alert mode flags stick until configuration register is read.
// R17: Therm mode high flag hysteresis at conversion end; low flag zero.
// R18: Alarm level bit 0 gives active-low pin, 1 active-high.
// R19: Writes to other registers blocked while programming.
// R20: Rate codes map to periods through a parameter table.
module tsens_regs #(
  parameter logic [23:0] RATE_PERIOD [8] = '{24'h000400, 24'h000800,
    24'h001000, 24'h002000, 24'h004000, 24'h008000, 24'h010000, 24'h020000},
  parameter logic [23:0] CONV_TIME = 24'h000200,
  parameter int unsigned PROG_CYCLES = `NVM_PROG_CYCLES
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Register access from serial front end
  input tsens_pkg::reg_req_t i_req,
  output logic [15:0] o_rdata,
  // Converter
  input tsens_pkg::conv_result_t i_conv,
  output logic o_conv_start,
  output logic o_conv_abort,
  // Nonvolatile copy and alarms
  output logic o_nvm_prog,
  output logic [15:0] o_nvm_data,
  output logic o_soft_reset,
  output logic o_alarm_out_a,
  output logic o_alarm_out_b
);
  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  logic [13:0] temp_code_reg, temp_code_next;
  logic nvm_unlock_state_reg, nvm_unlock_state_next;
  logic [15:0] cfg_reg, cfg_next;
  logic [15:0] lim_reg [4];
  logic [15:0] lim_next [4];
  logic [15:0] rdata_reg, rdata_next;
  logic prog_reg, prog_next;
  logic [15:0] nvm_data_reg, nvm_data_next;
  logic soft_reset_reg, soft_reset_next;
  logic nvm_busy;
  logic cfg_wr, cfg_rd, blocked;

  function automatic logic signed_gt(input logic [15:0] a,
                                     input logic [15:0] b);
    signed_gt = $signed(a) > $signed(b);
  endfunction

  tsens_nvm_timer #(.PROG_CYCLES(PROG_CYCLES)) u_timer (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_start(prog_reg),
    .o_busy(nvm_busy)
  );

  // Programming keeps all writes out until the copy is settled
  assign blocked = nvm_busy || prog_reg; // R19 R3
  assign cfg_wr = i_req.wr && i_req.ptr == `PTR_CONFIG && !blocked;
  assign cfg_rd = i_req.rd && i_req.ptr == `PTR_CONFIG;

  // ------------------------------------------------------------
  // Conversion sequencing
  // ------------------------------------------------------------
  tsens_pkg::conv_state_t st_reg, st_next;
  logic [23:0] tmr_reg, tmr_next;
  logic conv_end;
  logic [15:0] temp_word;
  assign conv_end = i_conv.valid && st_reg != tsens_pkg::CONV_IDLE;
  assign temp_word = {i_conv.code, 2'b00};

  always_comb begin
    st_next = st_reg;
    tmr_next = tmr_reg;
    o_conv_start = 1'b0;
    o_conv_abort = 1'b0;
    if (cfg_wr) begin
      // Any write while converting aborts; new bits decide the next step
      o_conv_abort = st_reg != tsens_pkg::CONV_IDLE; // R8 R9
      tmr_next = RATE_PERIOD[i_req.data[`BIT_RATE_HI:`BIT_RATE_LO]]; // R9
      if (!i_req.data[`BIT_POWERDOWN]) begin // R13
        st_next = tsens_pkg::CONV_RUN;
        o_conv_start = 1'b1;
      end else if (i_req.data[`BIT_SINGLE]) begin // R11
        st_next = tsens_pkg::CONV_SINGLE;
        o_conv_start = 1'b1;
      end else begin
        st_next = tsens_pkg::CONV_IDLE; // R8
      end
    end else begin
      case (st_reg)
        tsens_pkg::CONV_IDLE: begin
          st_next = tsens_pkg::CONV_IDLE;
        end
        tsens_pkg::CONV_RUN: begin
          // Rate table sets the restart period
          if (tmr_reg == 24'h000000) begin // R20 R10
            tmr_next = RATE_PERIOD[cfg_reg[`BIT_RATE_HI:`BIT_RATE_LO]];
            o_conv_start = 1'b1;
          end else begin
            tmr_next = tmr_reg - 24'h000001;
          end
        end
        tsens_pkg::CONV_SINGLE: begin
          if (i_conv.valid) begin
            st_next = tsens_pkg::CONV_IDLE; // R11
          end
        end
        default: begin
          st_next = tsens_pkg::CONV_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      st_reg <= tsens_pkg::CONV_RUN;
      tmr_reg <= 24'h000000;
    end else begin
      st_reg <= st_next;
      tmr_reg <= tmr_next;
    end
  end

  // ------------------------------------------------------------
  // Register updates
  // ------------------------------------------------------------
  always_comb begin
    temp_code_next = temp_code_reg;
    nvm_unlock_state_next = nvm_unlock_state_reg;
    cfg_next = cfg_reg;
    lim_next = lim_reg;
    prog_next = 1'b0;
    nvm_data_next = nvm_data_reg;
    soft_reset_next = 1'b0;
    if (conv_end) begin
      temp_code_next = i_conv.code; // R1
    end
    // Read clears alert flags; a same-cycle new event still sets them
    if (cfg_rd) begin
      if (!cfg_reg[`BIT_BEHAV_A]) begin
        cfg_next[`BIT_OVER_A] = 1'b0; // R16
        cfg_next[`BIT_UNDER_A] = 1'b0;
      end
      if (!cfg_reg[`BIT_BEHAV_B]) begin
        cfg_next[`BIT_OVER_B] = 1'b0;
        cfg_next[`BIT_UNDER_B] = 1'b0;
      end
    end
    if (cfg_wr) begin
      // Only writable fields taken; flags and trigger untouched
      cfg_next[15:13] = i_req.data[15:13]; // R10
      cfg_next[`BIT_POWERDOWN] = i_req.data[`BIT_POWERDOWN]; // R15
      cfg_next[`BIT_BEHAV_A] = i_req.data[`BIT_BEHAV_A];
      cfg_next[`BIT_LEVEL_A] = i_req.data[`BIT_LEVEL_A];
      cfg_next[`BIT_BEHAV_B] = i_req.data[`BIT_BEHAV_B];
      cfg_next[`BIT_LEVEL_B] = i_req.data[`BIT_LEVEL_B];
      soft_reset_next = i_req.data[`BIT_SOFT_RESET];
      if (nvm_unlock_state_reg) begin
        prog_next = 1'b1; // R7
        nvm_data_next = i_req.data & 16'hf99a;
      end // R6
    end
    if (i_req.wr && !blocked) begin
      if (i_req.ptr == `PTR_TEMP) begin
        nvm_unlock_state_next = i_req.data[0]; // R4
      end
      if (i_req.ptr >= `PTR_HIGH_A && i_req.ptr <= `PTR_LOW_B) begin
        lim_next[i_req.ptr[1:0] - 2'd2] = i_req.data;
      end
    end
    if (conv_end) begin
      if (signed_gt(temp_word, lim_reg[0])) begin
        cfg_next[`BIT_OVER_A] = 1'b1; // R14
      end else if (cfg_reg[`BIT_BEHAV_A]
                   && signed_gt(lim_reg[1], temp_word)) begin
        cfg_next[`BIT_OVER_A] = 1'b0; // R17
      end
      if (signed_gt(temp_word, lim_reg[2])) begin
        cfg_next[`BIT_OVER_B] = 1'b1;
      end else if (cfg_reg[`BIT_BEHAV_B]
                   && signed_gt(lim_reg[3], temp_word)) begin
        cfg_next[`BIT_OVER_B] = 1'b0;
      end
      if (!cfg_reg[`BIT_BEHAV_A] && signed_gt(lim_reg[1], temp_word)) begin
        cfg_next[`BIT_UNDER_A] = 1'b1;
      end
      if (!cfg_reg[`BIT_BEHAV_B] && signed_gt(lim_reg[3], temp_word)) begin
        cfg_next[`BIT_UNDER_B] = 1'b1;
      end
    end
    if (cfg_next[`BIT_BEHAV_A]) begin
      cfg_next[`BIT_UNDER_A] = 1'b0; // R17
    end
    if (cfg_next[`BIT_BEHAV_B]) begin
      cfg_next[`BIT_UNDER_B] = 1'b0;
    end
    cfg_next[`BIT_SINGLE] = 1'b0; // R12
    cfg_next[2:0] = 3'b000; // R15
  end

  always_comb begin
    rdata_next = rdata_reg;
    if (i_req.rd) begin
      case (i_req.ptr)
        `PTR_TEMP: rdata_next = {temp_code_reg, nvm_busy,
                                 nvm_unlock_state_reg}; // R1 R2 R4
        `PTR_CONFIG: rdata_next = cfg_reg; // R5
        `PTR_HIGH_A: rdata_next = lim_reg[0];
        `PTR_LOW_A: rdata_next = lim_reg[1];
        `PTR_HIGH_B: rdata_next = lim_reg[2];
        `PTR_LOW_B: rdata_next = lim_reg[3];
        default: rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      temp_code_reg <= `TEMP_RESET;
      nvm_unlock_state_reg <= 1'b0;
      cfg_reg <= `CONFIG_RESET;
      lim_reg[0] <= `LIMIT_HIGH_RESET;
      lim_reg[1] <= `LIMIT_LOW_RESET;
      lim_reg[2] <= `LIMIT_HIGH_RESET;
      lim_reg[3] <= `LIMIT_LOW_RESET;
      rdata_reg <= 16'h0000;
      prog_reg <= 1'b0;
      nvm_data_reg <= 16'h0000;
      soft_reset_reg <= 1'b0;
    end else begin
      temp_code_reg <= temp_code_next;
      nvm_unlock_state_reg <= nvm_unlock_state_next;
      cfg_reg <= cfg_next;
      lim_reg <= lim_next;
      rdata_reg <= rdata_next;
      prog_reg <= prog_next;
      nvm_data_reg <= nvm_data_next;
      soft_reset_reg <= soft_reset_next;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign o_rdata = rdata_reg;
  assign o_nvm_prog = prog_reg;
  assign o_nvm_data = nvm_data_reg;
  assign o_soft_reset = soft_reset_reg;
  // Alarm pin asserted while either flag of the pair is up
  assign o_alarm_out_a = (cfg_reg[`BIT_OVER_A] | cfg_reg[`BIT_UNDER_A])
                         ~^ cfg_reg[`BIT_LEVEL_A]; // R18
  assign o_alarm_out_b = (cfg_reg[`BIT_OVER_B] | cfg_reg[`BIT_UNDER_B])
                         ~^ cfg_reg[`BIT_LEVEL_B];

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_prog_write;
    cfg_wr && nvm_unlock_state_reg;
  endsequence
  a_prog_on_unlock: assert property (@(posedge i_clk) disable iff // R7
    (!i_resetn) s_prog_write |=> o_nvm_prog ##1 nvm_busy)
    else $error("unlocked write did not program");
  a_locked_no_prog: assert property (@(posedge i_clk) disable iff // R6
    (!i_resetn) (cfg_wr && !nvm_unlock_state_reg) |=> !o_nvm_prog)
    else $error("locked write programmed");
  a_blocked_writes: assert property (@(posedge i_clk) disable iff // R19
    (!i_resetn) (nvm_busy && i_req.wr) |=> $stable(cfg_reg[15:11]))
    else $error("write accepted while busy");
  a_trigger_zero: assert property (@(posedge i_clk) disable iff // R12 R15
    (!i_resetn) !cfg_reg[`BIT_SINGLE] && cfg_reg[2:0] == 3'b000)
    else $error("trigger or reserved bit nonzero");
  a_shutdown_stops: assert property (@(posedge i_clk) disable iff // R8
    (!i_resetn) (cfg_wr && i_req.data[`BIT_POWERDOWN]
    && !i_req.data[`BIT_SINGLE]) |=> st_reg == tsens_pkg::CONV_IDLE)
    else $error("shutdown not immediate");
  a_single_done: assert property (@(posedge i_clk) disable iff // R11
    (!i_resetn) (st_reg == tsens_pkg::CONV_SINGLE && i_conv.valid
    && !cfg_wr) |=> st_reg == tsens_pkg::CONV_IDLE)
    else $error("single conversion did not return to shutdown");
  a_therm_low_zero: assert property (@(posedge i_clk) disable iff // R17
    (!i_resetn) cfg_reg[`BIT_BEHAV_A] |-> !cfg_reg[`BIT_UNDER_A])
    else $error("low flag set in therm mode");
  a_temp_update: assert property (@(posedge i_clk) disable iff // R1
    (!i_resetn) conv_end |=> temp_code_reg == $past(i_conv.code))
    else $error("result not captured");
  a_read_clears: assert property (@(posedge i_clk) disable iff // R16
    (!i_resetn) (cfg_rd && !cfg_reg[`BIT_BEHAV_A] && !conv_end)
    |=> !cfg_reg[`BIT_OVER_A])
    else $error("alert flag not cleared by read");
endmodule

// ---- tsens_conv_model.sv ----
`timescale 1ns/10ps
module tsens_conv_model #(
  parameter int DELAY = 6
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Control from the register block
  input wire logic i_start,
  input wire logic i_abort,
  input wire logic [13:0] i_code,
  // Result
  output tsens_pkg::conv_result_t o_conv
);
  int count_reg;
  // Start wins over abort: a config write restarts at once
  always_ff @(posedge i_clk) begin
    o_conv.valid <= 1'b0;
    o_conv.code <= ~o_conv.code;
    if (!i_resetn) begin
      count_reg <= 0;
      o_conv.code <= 14'h0000;
    end else if (i_start) begin
      count_reg <= DELAY;
    end else if (i_abort) begin
      count_reg <= 0;
    end else if (count_reg != 0) begin
      count_reg <= count_reg - 1;
      if (count_reg == 1) begin
        o_conv.valid <= 1'b1;
        o_conv.code <= i_code;
      end
    end
  end
endmodule

// ---- temp_sensor_status_config_regs_test.sv ----
`timescale 1ns/10ps
module temp_sensor_status_config_regs_test;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  tsens_pkg::reg_req_t req = '0;
  tsens_pkg::conv_result_t conv;
  logic [15:0] rdata, nvm_data;
  logic [13:0] code = 14'h0000;
  logic start, abort, prog, soft_rst, alarm_a, alarm_b, ab, sw;
  int failures = 0;
  int check_count = 0;
  always #25 i_clk = ~i_clk;

  tsens_regs #(.RATE_PERIOD('{8{24'h000020}}), .PROG_CYCLES(20)) dut_u (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_req(req), .o_rdata(rdata),
    .i_conv(conv), .o_conv_start(start), .o_conv_abort(abort),
    .o_nvm_prog(prog), .o_nvm_data(nvm_data), .o_soft_reset(soft_rst),
    .o_alarm_out_a(alarm_a), .o_alarm_out_b(alarm_b));
  tsens_conv_model conv_u (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_start(start),
    .i_abort(abort), .i_code(code), .o_conv(conv));

  // ----------------------------------------
  // Bus tasks and checks
  // ----------------------------------------
  task automatic complete_run();
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Abort and start are combinational, so both are sampled in the cycle
  task automatic do_wr(input logic [3:0] p, input logic [15:0] d);
    @(posedge i_clk);
    req <= '{wr: 1'b1, rd: 1'b0, ptr: p, data: d};
    #1 ab = abort;
    sw = start;
    @(posedge i_clk);
    req <= '0;
    #1;
  endtask
  task automatic do_rd(input logic [3:0] p, output logic [15:0] d);
    @(posedge i_clk);
    req <= '{wr: 1'b0, rd: 1'b1, ptr: p, data: 16'h0000};
    @(posedge i_clk);
    req <= '0;
    #1 d = rdata;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [15:0] v;
    do_rd(4'h1, v);
    chk(v, 16'ha000);
    do_rd(4'h0, v);
    chk(v, 16'h0000);
    chk({15'h0, alarm_a}, 16'h0001);
    chk({15'h0, alarm_b}, 16'h0001);
  endtask
  task automatic t_conv();
    logic [15:0] v;
    int n;
    code <= 14'h1234;
    v = 16'h0000;
    for (n = 0; n < 60 && v !== 16'h48d0; n++) do_rd(4'h0, v);
    chk(v, 16'h48d0);
  endtask
  // Shutdown, one single shot, sticky flag cleared by the read
  task automatic t_single();
    logic [15:0] v;
    int n;
    int k;
    do_wr(4'h2, 16'h1000);
    do_wr(4'h1, 16'h0800);
    chk({15'h0, ab}, 16'h0001);
    repeat (20) @(posedge i_clk);
    do_wr(4'h1, 16'h1800);
    for (n = 0; n < 40 && conv.valid !== 1'b1; n++) @(negedge i_clk);
    chk(16'(n < 40), 16'h0001);
    repeat (2) @(posedge i_clk);
    do_rd(4'h1, v);
    chk(v, 16'h0c00);
    do_rd(4'h1, v);
    chk(v, 16'h0800);
    k = 0;
    repeat (40) begin
      @(negedge i_clk);
      k += int'(start);
    end
    chk(16'(k), 16'h0000);
  endtask
  task automatic t_bits();
    logic [15:0] v;
    do_wr(4'h1, 16'h0ee7);
    chk({15'h0, soft_rst}, 16'h0001);
    do_rd(4'h1, v);
    chk(v, 16'h0880);
    chk({15'h0, alarm_a}, 16'h0000);
  endtask
  task automatic t_nvm();
    logic [15:0] v;
    int n;
    do_wr(4'h0, 16'h0001);
    do_rd(4'h0, v);
    chk(v, 16'h48d1);
    do_wr(4'h1, 16'h0998);
    chk({15'h0, prog}, 16'h0001);
    chk(nvm_data, 16'h0998);
    do_wr(4'h2, 16'h2000);
    do_rd(4'h0, v);
    chk(v, 16'h48d3);
    for (n = 0; n < 40 && v[1] !== 1'b0; n++) do_rd(4'h0, v);
    if (n == 40) begin
      failures++;
      complete_run();
    end
    do_rd(4'h2, v);
    chk(v, 16'h1000);
    do_wr(4'h0, 16'h0000);
    do_wr(4'h1, 16'h0800);
    chk({15'h0, prog}, 16'h0000);
  endtask
  // Therm hysteresis on pair A; a rewrite while running restarts it
  task automatic t_therm();
    logic [15:0] v;
    int n;
    do_wr(4'h3, 16'h0800);
    do_wr(4'h1, 16'h0100);
    chk({15'h0, sw}, 16'h0001);
    do_wr(4'h1, 16'h2100);
    chk({14'h0, ab, sw}, 16'h0003);
    v = 16'h0000;
    for (n = 0; n < 40 && v !== 16'h2500; n++) do_rd(4'h1, v);
    chk(v, 16'h2500);
    chk({15'h0, alarm_a}, 16'h0000);
    code <= 14'h0300;
    for (n = 0; n < 60 && v !== 16'h0c00; n++) do_rd(4'h0, v);
    chk(v, 16'h0c00);
    do_rd(4'h1, v);
    chk(v, 16'h2500);
    code <= 14'h0100;
    for (n = 0; n < 60 && v !== 16'h0400; n++) do_rd(4'h0, v);
    do_rd(4'h1, v);
    chk(v, 16'h2100);
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge i_clk);
    i_resetn <= 1'b1;
    t_reset();
    t_conv();
    t_single();
    t_bits();
    t_nvm();
    t_therm();
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    failures++;
    complete_run();
  end
endmodule
